// File: hw/fld_cfg.svh
`ifndef FLD_CFG_SVH
`define FLD_CFG_SVH

// Register indices; the byte address is four times the index.
`define FLD_IDX_FB_DIV_LOW   8'h10
`define FLD_IDX_SPEEDUP      8'h1B
`define FLD_IDX_NORM_GAIN    8'h1C
`define FLD_IDX_BOOST_HIGH   8'h1D
`define FLD_IDX_MON_LOW      8'h1E
`define FLD_IDX_MON_HIGH     8'h1F
`define FLD_IDX_TIMER_LOW    8'h20
`define FLD_IDX_PASS_CNT     8'h21
`define FLD_IDX_ERR_WIN      8'h22
`define FLD_IDX_IRQ_STATUS   8'h40
`define FLD_IDX_IRQ_MASK     8'h41

// Reset values.
`define FLD_RST_SPEEDUP      8'h08
`define FLD_RST_FLOOR        6'h0A
`define FLD_RST_CEILING      6'h32
`define FLD_RST_PASS         8'hFF

// Field positions.
`define FLD_CSF_LSB          5
`define FLD_TMR_HI_LSB       5
`define FLD_WIN_LSB          5
`define FLD_FLAG_BIT         6

// Timer granule in phase detector cycles (a shift by five is times 32).
`define FLD_TMR_SHIFT        5

// Edge window limits, in tenths of a nanosecond.
`define FLD_WIN_0            8'h0A
`define FLD_WIN_1            8'h11
`define FLD_WIN_2            8'h1E
`define FLD_WIN_3            8'h3C
`define FLD_WIN_4            8'h64
`define FLD_WIN_5            8'hB4

// Interrupt status bits.
`define FLD_IRQ_EXPIRE       0
`define FLD_IRQ_LOCK         1
`define FLD_IRQ_UNLOCK       2
`define FLD_IRQ_PUMP         3
`define FLD_IRQ_W            4

`endif

// File: hw/fld_pkg.sv
`default_nettype none
package fld_pkg;

  // Digital lock detector state.
  typedef enum logic [0:0] {
    FLD_UNLOCKED = 1'b0,
    FLD_LOCKED   = 1'b1
  } fld_lock_t;

  // Boost timer state.
  typedef enum logic [0:0] {
    FLD_IDLE = 1'b0,
    FLD_RUN  = 1'b1
  } fld_timer_t;

endpackage : fld_pkg

`default_nettype wire

// File: hw/fld_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fld_cfg.svh"

module fld_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pd_edge,
  input  wire logic [7:0]  edge_skew,
  input  wire logic [5:0]  pump_volt_code,
  input  wire logic        ramp_active,
  input  wire logic        ramp_boost_select,
  output logic      [4:0]  pump_gain_out,
  output logic      [1:0]  div_scale_shift,
  output logic             boost_active,
  output logic             edge_lock_state,
  output logic             combined_lock_output,
  output logic             irq
);

  // Register storage. Each register is one byte in the low bits of an
  // aligned word; the upper bits of every word read as zero and are
  // ignored on write. The map, by word index:
  //   0x10  feedback divider low byte; any write restarts the boost timer.
  //   0x1B  speed-up control; bits 6:5 pick the cycle slip factor.
  //   0x1C  normal pump gain in bits 4:0.
  //   0x1D  boost pump gain in bits 4:0, timer code bits 10:8 in 7:5.
  //   0x1E  pump floor in bits 5:0, floor flag in bit 6 (read only).
  //   0x1F  pump ceiling in bits 5:0, ceiling flag in bit 6 (read only).
  //   0x20  timer code bits 7:0.
  //   0x21  good edge target of the lock detector.
  //   0x22  error allowance in bits 4:0, edge window code in bits 7:5.
  //   0x40  interrupt status, write one to clear.
  //   0x41  interrupt mask, same layout as the status.
  // Words that are not listed read zero and ignore writes.
  logic [7:0] fb_div_low;
  logic [7:0] speedup_divider_config;
  logic [4:0] normal_pump_gain;
  logic [7:0] boost_gain_timer_high;
  logic [5:0] pump_volt_floor;
  logic [5:0] pump_volt_ceiling;
  logic [7:0] boost_timer_low;
  logic [7:0] lock_pass_count;
  logic [7:0] lock_error_window;
  logic [`FLD_IRQ_W-1:0] irq_status;
  logic [`FLD_IRQ_W-1:0] irq_mask;

  // Live state. The timer counts phase detector edges, not bus clocks,
  // so its length in time follows the phase detector rate; the bus
  // clock only has to run faster than that rate for no edge to be lost.
  fld_pkg::fld_timer_t timer_state;
  fld_pkg::fld_lock_t  lock_state;
  logic [15:0] timer_count;
  logic [7:0]  good_count;
  logic [4:0]  error_count;
  logic        pump_good_q;

  // APB decode. The access phase takes two cycles so read data and
  // the ready strobe both come from flip-flops.
  // Walk of one transfer: the select rises after edge 0 and the enable
  // after edge 1; ready and read data are loaded at edge 2 and sampled
  // by the master at edge 3, which is also the edge at which a write
  // lands. The next setup may follow right after edge 3. A word outside
  // the map or a misaligned address answers with an error and no effect.
  wire       access   = psel & penable;
  wire       fire     = access & pready;
  wire [7:0] idx      = paddr[9:2];
  wire       aligned  = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);
  wire       hit_fb   = aligned & (idx == `FLD_IDX_FB_DIV_LOW);
  wire       hit_su   = aligned & (idx == `FLD_IDX_SPEEDUP);
  wire       hit_ng   = aligned & (idx == `FLD_IDX_NORM_GAIN);
  wire       hit_bh   = aligned & (idx == `FLD_IDX_BOOST_HIGH);
  wire       hit_ml   = aligned & (idx == `FLD_IDX_MON_LOW);
  wire       hit_mh   = aligned & (idx == `FLD_IDX_MON_HIGH);
  wire       hit_tl   = aligned & (idx == `FLD_IDX_TIMER_LOW);
  wire       hit_pc   = aligned & (idx == `FLD_IDX_PASS_CNT);
  wire       hit_ew   = aligned & (idx == `FLD_IDX_ERR_WIN);
  wire       hit_is   = aligned & (idx == `FLD_IDX_IRQ_STATUS);
  wire       hit_im   = aligned & (idx == `FLD_IDX_IRQ_MASK);
  wire       mapped   = hit_fb | hit_su | hit_ng | hit_bh | hit_ml |
                        hit_mh | hit_tl | hit_pc | hit_ew | hit_is |
                        hit_im;
  wire       wr       = fire & pwrite & mapped;
  wire [7:0] wbyte    = pwdata[7:0];

  // Pump voltage comparators. A code equal to a threshold counts as
  // inside the good range, so a pump parked on a threshold does not
  // chatter the lock output. The flags are live and not latched; a
  // read shows the comparison at the edge that loads the read data.
  wire floor_flag   = pump_volt_code > pump_volt_floor;
  wire ceiling_flag = pump_volt_code > pump_volt_ceiling;
  wire below_floor  = pump_volt_code < pump_volt_floor;
  wire pump_good    = ~below_floor & ~ceiling_flag;

  // Read multiplexer; unused bits and unmapped words read zero. Bit 7
  // of both monitor words reads zero and the flag bits ignore writes.
  wire [7:0] rd_byte =
    hit_fb ? fb_div_low :
    hit_su ? speedup_divider_config :
    hit_ng ? {3'h0, normal_pump_gain} :
    hit_bh ? boost_gain_timer_high :
    hit_ml ? {1'b0, floor_flag, pump_volt_floor} :
    hit_mh ? {1'b0, ceiling_flag, pump_volt_ceiling} :
    hit_tl ? boost_timer_low :
    hit_pc ? lock_pass_count :
    hit_ew ? lock_error_window :
    hit_is ? {4'h0, irq_status} :
    hit_im ? {4'h0, irq_mask} :
    8'h00;

  // Ready rises one cycle into the access phase and drops after. The
  // extra wait state is traded for a registered read path: the mux above
  // is deep, and registering it keeps the bus outputs free of glitches.
  // Read data is forced to zero outside the answering cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      prdata  <= (access & ~pready & ~pwrite) ? {24'h00_0000, rd_byte}
                                               : 32'h0000_0000;
    end
  end

  // Configuration registers, written at the completing edge only.
  // An erroring transfer never writes, since wr requires a mapped word.
  // The speed-up register resets to 0x08 so that its pulse-width field,
  // which belongs to the pump and is only stored here, keeps its
  // default value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_div_low             <= 8'h00;
      speedup_divider_config <= `FLD_RST_SPEEDUP;
      normal_pump_gain       <= 5'h00;
      boost_gain_timer_high  <= 8'h00;
      pump_volt_floor        <= `FLD_RST_FLOOR;
      pump_volt_ceiling      <= `FLD_RST_CEILING;
      boost_timer_low        <= 8'h00;
      lock_pass_count        <= `FLD_RST_PASS;
      lock_error_window      <= 8'h00;
      irq_mask               <= 4'h0;
    end else if (wr) begin
      if (hit_fb) fb_div_low <= wbyte;
      if (hit_su) speedup_divider_config <= wbyte;
      if (hit_ng) normal_pump_gain <= wbyte[4:0];
      if (hit_bh) boost_gain_timer_high <= wbyte;
      if (hit_ml) pump_volt_floor <= wbyte[5:0];
      if (hit_mh) pump_volt_ceiling <= wbyte[5:0];
      if (hit_tl) boost_timer_low <= wbyte;
      if (hit_pc) lock_pass_count <= wbyte;
      if (hit_ew) lock_error_window <= wbyte;
      if (hit_im) irq_mask <= wbyte[3:0];
    end
  end

  // Boost timer. The eleven-bit code spans two registers.
  // The loaded count is the code times 32, so the longest run is 65504
  // phase detector edges. The run ends on the edge that takes the count
  // from one to zero; that expiry pulse also sets the timer status bit.
  wire [10:0] timer_code = {boost_gain_timer_high[7:`FLD_TMR_HI_LSB],
                            boost_timer_low};
  wire [15:0] timer_load = {timer_code, 5'h00};
  wire        start_tmr  = wr & hit_fb;
  wire        timer_end  = (timer_state == fld_pkg::FLD_RUN) &
                           pd_edge & (timer_count == 16'h0001);

  // A code of zero leaves the timer idle; a new write restarts it.
  // A restart in mid-run reloads the full count rather than adding to
  // what is left, so software sees one predictable boost length. The
  // count is parked at zero while idle so a stale value never leaks in.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_state <= fld_pkg::FLD_IDLE;
      timer_count <= 16'h0000;
    end else if (start_tmr) begin
      timer_state <= (timer_code != 11'h000) ? fld_pkg::FLD_RUN
                                             : fld_pkg::FLD_IDLE;
      timer_count <= timer_load;
    end else begin
      case (timer_state)
        fld_pkg::FLD_RUN: begin
          if (timer_end) begin
            timer_state <= fld_pkg::FLD_IDLE;
          end
          if (pd_edge) begin
            timer_count <= timer_count - 16'h0001;
          end
        end
        fld_pkg::FLD_IDLE: begin
          timer_count <= 16'h0000;
        end
        default: begin
          timer_state <= fld_pkg::FLD_IDLE;
        end
      endcase
    end
  end

  // Boost applies while the timer runs or a boosted ramp executes.
  // The ramp engine owns both ramp inputs; they are taken as levels and
  // are not checked against each other here.
  wire       timer_run = timer_state == fld_pkg::FLD_RUN;
  wire       boosting  = timer_run |
                         (ramp_active & ramp_boost_select);
  wire [1:0] csf       = speedup_divider_config[`FLD_CSF_LSB+1:`FLD_CSF_LSB];

  // Code three is reserved and treated as no scaling.
  // Software is expected never to program it; mapping it to no scaling
  // keeps the dividers at their programmed values if it does.
  wire [1:0] csf_shift = (csf == 2'h3) ? 2'h0 : csf;

  // The divider datapath shifts both R and N by this amount; the shift
  // falls to zero the cycle after boosting ends.
  // Gain and shift switch on the same edge, so the pump never sees the
  // boost gain with the normal dividers or the other way round. Gain
  // code zero leaves the pump in tri-state, as in normal operation.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_scale_shift <= 2'h0;
      pump_gain_out   <= 5'h00;
      boost_active    <= 1'b0;
    end else begin
      div_scale_shift <= boosting ? csf_shift : 2'h0;
      pump_gain_out   <= boosting ? boost_gain_timer_high[4:0]
                                  : normal_pump_gain;
      boost_active    <= boosting;
    end
  end

  // Edge window in tenths of a nanosecond; reserved codes take the
  // widest window so a bad code never makes lock harder to find.
  // The limits are 1, 1.7, 3, 6, 10 and 18 ns. An edge exactly on the
  // limit counts as good.
  wire [2:0] win_code = lock_error_window[7:`FLD_WIN_LSB];
  wire [7:0] win_lim  =
    (win_code == 3'h0) ? `FLD_WIN_0 :
    (win_code == 3'h1) ? `FLD_WIN_1 :
    (win_code == 3'h2) ? `FLD_WIN_2 :
    (win_code == 3'h3) ? `FLD_WIN_3 :
    (win_code == 3'h4) ? `FLD_WIN_4 :
    `FLD_WIN_5;
  wire good_edge = pd_edge & (edge_skew <= win_lim);
  wire err_edge  = pd_edge & (edge_skew >  win_lim);

  // Count limits. The counts compare their next values, so the edge that
  // reaches a limit is itself the one that ends the round. With an
  // allowance of zero every error edge trips and lock is never gained.
  wire [4:0] err_allow  = lock_error_window[4:0];
  wire [7:0] next_good  = good_count + 8'h01;
  wire [4:0] next_error = error_count + 5'h01;
  wire       pass_done  = good_edge & (next_good >= lock_pass_count);
  wire       err_trip   = err_edge & (next_error >= err_allow);
  wire       gain_lock  = pass_done & (error_count < err_allow);

  // Lock detector. A filter round ends either when enough good edges
  // are seen (lock) or when the error allowance is used up (unlock).
  // A round that reaches its target with too many errors leaves the
  // state as it is; the error trip alone handles the way down. Both
  // counters restart after every decision.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_state  <= fld_pkg::FLD_UNLOCKED;
      good_count  <= 8'h00;
      error_count <= 5'h00;
    end else if (err_trip) begin
      lock_state  <= fld_pkg::FLD_UNLOCKED;
      good_count  <= 8'h00;
      error_count <= 5'h00;
    end else if (pass_done) begin
      if (gain_lock) begin
        lock_state <= fld_pkg::FLD_LOCKED;
      end
      good_count  <= 8'h00;
      error_count <= 5'h00;
    end else begin
      case (lock_state)
        fld_pkg::FLD_UNLOCKED,
        fld_pkg::FLD_LOCKED: begin
          if (good_edge) begin
            good_count <= next_good;
          end
          if (err_edge) begin
            error_count <= next_error;
          end
        end
        default: begin
          lock_state <= fld_pkg::FLD_UNLOCKED;
        end
      endcase
    end
  end

  // Lock outputs. The pump check is registered once so both outputs
  // change on the same edge.
  // The pump check is not filtered: one code outside the range drops the
  // combined output on the next edge, which is what a lock pin wants.
  wire dld_good = lock_state == fld_pkg::FLD_LOCKED;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_lock_state      <= 1'b0;
      combined_lock_output <= 1'b0;
      pump_good_q          <= 1'b0;
    end else begin
      edge_lock_state      <= dld_good;
      combined_lock_output <= dld_good & pump_good;
      pump_good_q          <= pump_good;
    end
  end

  // Interrupt events. Each is a one-cycle pulse.
  // Lock events are taken from the registered lock output, so their
  // status bits set one cycle after the detector state moves. The pump
  // event fires when the voltage leaves the good range, not on return.
  wire ev_lock   = dld_good & ~edge_lock_state;
  wire ev_unlock = ~dld_good & edge_lock_state;
  wire ev_pump   = pump_good_q & ~pump_good;
  wire [3:0] ev  = {ev_pump, ev_unlock, ev_lock, timer_end};

  // Write-one-to-clear; an event in the clearing cycle still sets the bit.
  wire [3:0] clr = (wr & hit_is) ? wbyte[3:0] : 4'h0;
  wire [3:0] next_status = (irq_status & ~clr) | ev;

  // Status and the level interrupt both come from flip-flops.
  // The interrupt output looks at the next status, so a new event is
  // seen on the same edge that sets its bit; a mask change takes effect
  // one edge after it is written.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 4'h0;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_status;
      irq        <= |(next_status & irq_mask);
    end
  end

endmodule : fld_top

`default_nettype wire

// File: verif/fld_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level watcher for the boost timer, lock detector and register bus.
module fld_top_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pd_edge,
  input wire logic [7:0]  edge_skew,
  input wire logic [5:0]  pump_volt_code,
  input wire logic        ramp_active,
  input wire logic        ramp_boost_select,
  input wire logic [4:0]  pump_gain_out,
  input wire logic [1:0]  div_scale_shift,
  input wire logic        boost_active,
  input wire logic        edge_lock_state,
  input wire logic        combined_lock_output,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Causes of boosting: a completed divider write or a boosted ramp.
  wire wr_div = psel && penable && pready && pwrite && (paddr[9:2] == 8'h10);
  wire ramp_b = ramp_active && ramp_boost_select;
  property p_no_slip3; div_scale_shift != 2'h3; endproperty
  a_no_slip3: assert property (p_no_slip3) else $error("slip shift out of range");
  property p_idle_noscale; !boost_active |-> div_scale_shift == 2'h0; endproperty
  a_idle_noscale: assert property (p_idle_noscale) else $error("scaling while idle");
  property p_boost_cause;
    $rose(boost_active) |-> $past(wr_div, 2) || $past(wr_div, 3) || $past(ramp_b, 1)
      || $past(ramp_b, 2) || $past(ramp_b, 3);
  endproperty
  a_boost_cause: assert property (p_boost_cause) else $error("boost without cause");
  property p_rst_state; $rose(presetn) |-> !edge_lock_state && !boost_active; endproperty
  a_rst_state: assert property (p_rst_state) else $error("state after reset");
  property p_lock_edge;
    $changed(edge_lock_state) |-> $past(pd_edge, 1) || $past(pd_edge, 2);
  endproperty
  a_lock_edge: assert property (p_lock_edge) else $error("lock moved without edge");
  property p_comb; combined_lock_output |-> edge_lock_state; endproperty
  a_comb: assert property (p_comb) else $error("combined lock without lock");
  property p_ready; pready |-> $past(psel && penable) && !$past(pready); endproperty
  a_ready: assert property (p_ready) else $error("pready outside access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  c_boost: cover property ($rose(boost_active));
  c_lock: cover property ($rose(edge_lock_state));
  c_err: cover property (pslverr);
endmodule : fld_top_asserts
`default_nettype wire

// File: verif/test_fld_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fld_cfg.svh"
module test_fld_top;
  logic        pclk, presetn, psel, penable, pwrite, pd_edge, ramp_active, ramp_boost_select;
  logic        pready, pslverr, boost_active, edge_lock_state, combined_lock_output, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [7:0]  edge_skew, g, t;
  logic [5:0]  pump_volt_code;
  logic [4:0]  pump_gain_out;
  logic [1:0]  div_scale_shift;
  logic        rd_err;
  int          mismatches, checks, m_good, m_err, m_lock, n, tgt, alw;
  logic [7:0]  lim [6];
  fld_top fld_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pd_edge, .edge_skew, .pump_volt_code, .ramp_active,
    .ramp_boost_select, .pump_gain_out, .div_scale_shift, .boost_active, .edge_lock_state,
    .combined_lock_output, .irq);
  // Free-running bus clock.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task wt(input int c);
    repeat (c) @(posedge pclk);
  endtask : wt
  // One register transfer; the request stands until pready is sampled high.
  task apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] i, input logic [31:0] e);
    apb(1'b0, i, 8'h00);
    chk("reg", rd_data, e);
  endtask : rd
  // One detector edge, mirrored in the integer model before comparing.
  task pulse(input logic [7:0] sk, input logic [7:0] lm);
    @(posedge pclk);
    pd_edge <= 1'b1;
    edge_skew <= sk;
    @(posedge pclk);
    pd_edge <= 1'b0;
    if (sk <= lm) begin
      m_good++;
      if (m_good >= tgt) begin
        m_lock = (m_err < alw);
        m_good = 0;
        m_err = 0;
      end
    end else begin
      m_err++;
      if (m_err >= alw) begin
        m_lock = 0;
        m_good = 0;
        m_err = 0;
      end
    end
    wt(3);
    chk("lock", edge_lock_state, m_lock);
    chk("comb", combined_lock_output, m_lock);
  endtask : pulse
  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, pd_edge, ramp_active, ramp_boost_select} = 7'h00;
    {paddr, pwdata, edge_skew} = '0;
    pump_volt_code = 6'h20;
    lim = '{`FLD_WIN_0, `FLD_WIN_1, `FLD_WIN_2, `FLD_WIN_3, `FLD_WIN_4, `FLD_WIN_5};
    {mismatches, checks, m_good, m_err, m_lock, alw} = '0;
    tgt = 255;
    void'($urandom(32'hD265));
    wt(16);
    presetn <= 1'b1;
    wt(2);
    chk("rst", {edge_lock_state, boost_active}, 0);
    rd(`FLD_IDX_SPEEDUP, 32'h08);
    rd(`FLD_IDX_BOOST_HIGH, 32'h00);
    rd(`FLD_IDX_MON_LOW, 32'h4A);
    rd(`FLD_IDX_MON_HIGH, 32'h32);
    rd(`FLD_IDX_TIMER_LOW, 32'h00);
    rd(`FLD_IDX_PASS_CNT, 32'hFF);
    rd(`FLD_IDX_ERR_WIN, 32'h00);
    apb(1'b0, 8'h3F, 8'h00);
    chk("slverr", rd_err, 1);
    apb(1'b1, `FLD_IDX_NORM_GAIN, 8'h03);
    // Every slip code; the last run also sets timer code bit 8.
    for (int c = 0; c < 4; c++) begin
      g = 8'($urandom_range(31, 1));
      t = 8'($urandom_range(3, 1));
      apb(1'b1, `FLD_IDX_BOOST_HIGH, (c == 3) ? (g | 8'h20) : g);
      apb(1'b1, `FLD_IDX_TIMER_LOW, t);
      // The divider value is zero, so any slip factor keeps it in range.
      apb(1'b1, `FLD_IDX_SPEEDUP, 8'(8'h08 | (c << 5)));
      apb(1'b1, `FLD_IDX_FB_DIV_LOW, 8'h00);
      wt(3);
      chk("boost", boost_active, 1);
      chk("gain", pump_gain_out, g);
      chk("shift", div_scale_shift, (c == 3) ? 0 : c);
      n = 0;
      while (boost_active === 1'b1) begin
        pulse(8'h00, lim[0]);
        n++;
      end
      chk("len", n, ((c == 3) ? 256 + t : t) * 32);
      chk("gain", pump_gain_out, 3);
      chk("shift", div_scale_shift, 0);
    end
    apb(1'b1, `FLD_IDX_BOOST_HIGH, g);
    apb(1'b1, `FLD_IDX_TIMER_LOW, 8'h00);
    apb(1'b1, `FLD_IDX_FB_DIV_LOW, 8'h00);
    wt(4);
    chk("boost", boost_active, 0);
    // Ramp segments run with slip reduction off, as software should keep them.
    apb(1'b1, `FLD_IDX_SPEEDUP, 8'h08);
    ramp_active <= 1'b1;
    ramp_boost_select <= 1'b1;
    wt(4);
    chk("ramp", {boost_active, div_scale_shift, pump_gain_out}, {3'h4, g[4:0]});
    // Scaling under a boosted ramp is still checked once on the device side.
    apb(1'b1, `FLD_IDX_SPEEDUP, 8'h48);
    wt(4);
    chk("ramp", {boost_active, div_scale_shift, pump_gain_out}, {3'h6, g[4:0]});
    ramp_boost_select <= 1'b0;
    wt(4);
    chk("ramp", {boost_active, div_scale_shift, pump_gain_out}, 8'h03);
    ramp_active <= 1'b0;
    // Only the timer expiry bit can be set so far.
    rd(`FLD_IDX_IRQ_STATUS, 32'h01);
    // Second reset clears the detector before the window sweep.
    presetn <= 1'b0;
    wt(2);
    presetn <= 1'b1;
    {m_good, m_err, m_lock} = '0;
    tgt = 3;
    alw = 2;
    apb(1'b1, `FLD_IDX_PASS_CNT, 8'h03);
    for (int w = 0; w < 6; w++) begin
      apb(1'b1, `FLD_IDX_ERR_WIN, 8'((w << 5) | alw));
      repeat (3) pulse(lim[w], lim[w]);
      repeat (2) pulse(lim[w] + 8'h01, lim[w]);
      repeat (4) pulse(8'($urandom_range(lim[w] + 40)), lim[w]);
    end
    repeat (3) pulse(8'h00, lim[5]);
    pump_volt_code <= 6'h05;
    wt(4);
    chk("floor", combined_lock_output, 0);
    rd(`FLD_IDX_MON_LOW, 32'h0A);
    pump_volt_code <= 6'h3F;
    wt(4);
    chk("ceil", combined_lock_output, 0);
    rd(`FLD_IDX_MON_HIGH, 32'h72);
    pump_volt_code <= 6'h20;
    wt(4);
    chk("back", combined_lock_output, 1);
    rd(`FLD_IDX_IRQ_STATUS, 32'h0E);
    chk("irq", irq, 0);
    apb(1'b1, `FLD_IDX_IRQ_MASK, 8'h04);
    wt(2);
    chk("irq", irq, 1);
    apb(1'b1, `FLD_IDX_IRQ_STATUS, 8'h0F);
    wt(2);
    chk("irq", irq, 0);
    rd(`FLD_IDX_IRQ_STATUS, 32'h00);
    finish_test;
  end
  // The longest timer run is at most 41440 cycles; this bound leaves ample margin.
  initial begin
    wt(95000);
    mismatches++;
    finish_test;
  end
endmodule : test_fld_top
bind fld_top fld_top_asserts fld_top_asserts_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pd_edge, .edge_skew,
  .pump_volt_code, .ramp_active, .ramp_boost_select, .pump_gain_out, .div_scale_shift,
  .boost_active, .edge_lock_state, .combined_lock_output, .irq);
`default_nettype wire
